// file: sdcb_cmd_state.v
// Two-bank command decode and clock-enable state logic
// Notes on behaviour
// - Self-refresh exit edge needs deselect or nop
// - Recovery reaches idle after refresh cycle time
// - Clock enable falling in recovery gives power-down
// - Clock enable rising ends power-down, then idle
// - Clock enable rise wakes receivers, setup applies
// - Refresh with clock enable falling: self-refresh
// - Idle decode: nop, activate, refresh, mode set
// - Clock enable falling when busy starts suspend
// - Clock enable rising ends suspend next cycle
// - Clock enable high twice: normal command decode
// - Activate takes row, read/write take column
// - Auto-precharge bit picks read/write variant
// - Precharge one/both; mode set needs idle
// - Self-refresh ignores all but clock enable and the exit-edge command
// - Highest address bit selects the bank
`include "sdcb_defs.vh"
module sdcb_cmd_state
#(
  parameter ADDR_W = 12,
  parameter ROW_W = 11,
  parameter COL_W = 8
)
(
  // Clock and reset
  input wire CLK_SYS_I,
  input wire RST_N_I,
  // Command pins from the controller
  input wire CKE_I,
  input wire CS_N_I,
  input wire RAS_N_I,
  input wire CAS_N_I,
  input wire WE_N_I,
  input wire [ADDR_W-1:0] ADDR_I,
  // State outputs
  output reg [2:0] MODE_O,
  output reg [2:0] BANK0_STATE_O,
  output reg [2:0] BANK1_STATE_O,
  output reg [ROW_W-1:0] ROW_ADDRESS_O,
  output reg [COL_W-1:0] COLUMN_ADDRESS_O,
  output reg BANK_SEL_O,
  output reg [ADDR_W-1:0] MODE_REG_O,
  output reg ILLEGAL_O
);
  // ----------------------------------------
  // Refresh cycle time in clock cycles
  // ----------------------------------------
  localparam integer TRC_CYC_I = `SDCB_TRC_CYC;
  localparam [7:0] TRC_CYC = TRC_CYC_I[7:0];

  // Synchronised pins: cke, cs, ras, cas, we, address
  wire [ADDR_W+4:0] pins_s;
  wire cke;
  wire [3:0] cmd;
  wire [ADDR_W-1:0] addr;
  // Previous clock enable sample
  reg cke_prev;
  // Global mode and bank states
  reg [2:0] mode;
  reg [2:0] next_mode;
  reg [2:0] bk0;
  reg [2:0] bk1;
  reg [2:0] next_bk0;
  reg [2:0] next_bk1;
  reg next_illegal;
  // Refresh recovery counter
  reg [7:0] trc_cnt;
  wire both_idle;
  wire sel;
  wire ap;
  wire dec;

  // Pins come from another clock domain; enable and strobes pass inverted
  // so the zero reset of the synchroniser reads as enabled no-op
  sdcb_sync2 #(.W(ADDR_W + 5)) u_sync
  (
    .clk_i(CLK_SYS_I),
    .rst_n_i(RST_N_I),
    .d_i({~CKE_I, ~CS_N_I, ~RAS_N_I, ~CAS_N_I, ~WE_N_I, ADDR_I}),
    .q_o(pins_s)
  );

  assign cke = ~pins_s[ADDR_W+4];
  assign cmd = ~pins_s[ADDR_W+3:ADDR_W];
  assign addr = pins_s[ADDR_W-1:0];
  assign both_idle = (bk0 == `SDCB_BK_IDLE) && (bk1 == `SDCB_BK_IDLE);
  assign sel = addr[`SDCB_BANK_BIT];
  assign ap = addr[`SDCB_AP_BIT];
  // Clock enable high on both edges; decode below also runs on a falling edge
  assign dec = cke_prev && cke;

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  // Deselect or nop: chip select high, or row and column strobes high
  function is_nop;
    input [3:0] c;
    begin
      is_nop = c[3] || (c[2:1] == 2'b11);
    end
  endfunction

  // Bank running a burst
  function is_burst;
    input [2:0] s;
    begin
      is_burst = (s == `SDCB_BK_RD) || (s == `SDCB_BK_WR) ||
                 (s == `SDCB_BK_RDAP) || (s == `SDCB_BK_WRAP);
    end
  endfunction

  // Other bank after a read/write: burst ends, leaves it active unless it was idle
  function [2:0] other_after_rw;
    input [2:0] s;
    begin
      other_after_rw = (s == `SDCB_BK_IDLE) ? `SDCB_BK_IDLE : `SDCB_BK_ACT;
    end
  endfunction

  // Burst stop effect on one bank
  function [2:0] after_bst;
    input [2:0] s;
    begin
      after_bst = is_burst(s) ? `SDCB_BK_ACT : s;
    end
  endfunction

  // ----------------------------------------
  // Next-state decode
  // ----------------------------------------
  always @*
  begin
    next_mode = mode;
    next_bk0 = bk0;
    next_bk1 = bk1;
    next_illegal = 1'b0;
    case (mode)
      `SDCB_MD_SELFREF:
      begin
        // Only clock enable and the exit-edge command are looked at here
        if (!cke_prev && cke)
        begin
          next_mode = `SDCB_MD_SRREC;
          next_illegal = !is_nop(cmd);
        end
      end
      `SDCB_MD_SRREC:
      begin
        if (!is_nop(cmd))
          next_illegal = 1'b1;
        if (!cke)
          next_mode = `SDCB_MD_PDOWN;
        else if (trc_cnt == 8'h00)
          next_mode = `SDCB_MD_NORMAL;
      end
      `SDCB_MD_PDOWN:
      begin
        // Any command ignored on the waking edge, never flagged
        if (cke)
          next_mode = `SDCB_MD_NORMAL;
      end
      `SDCB_MD_SUSPEND:
      begin
        // Banks frozen until clock enable returns
        if (cke)
          next_mode = `SDCB_MD_NORMAL;
      end
      default:
      begin
        if (!cke_prev)
        begin
          // Clock enable already low: power-down from idle
          if (both_idle)
            next_mode = `SDCB_MD_PDOWN;
          else
            next_mode = `SDCB_MD_SUSPEND;
        end
        else if (!cke && both_idle && (cmd == `SDCB_CMD_REF))
          next_mode = `SDCB_MD_SELFREF;
        else if (!cke && !both_idle)
          next_mode = `SDCB_MD_SUSPEND;
        else if (!cke && both_idle && is_nop(cmd))
          next_mode = `SDCB_MD_PDOWN;
        // Command still takes effect on a falling enable edge,
        // except the refresh that starts self-refresh
        if (dec || (cke_prev && (next_mode != `SDCB_MD_SELFREF)))
        begin
          case (cmd)
            `SDCB_CMD_BST:
            begin
              next_bk0 = after_bst(bk0);
              next_bk1 = after_bst(bk1);
            end
            `SDCB_CMD_READ, `SDCB_CMD_WRITE:
            begin
              if (sel ? (bk1 == `SDCB_BK_IDLE) : (bk0 == `SDCB_BK_IDLE))
                next_illegal = 1'b1;
              else if (sel)
              begin
                next_bk1 = (cmd == `SDCB_CMD_READ) ?
                  (ap ? `SDCB_BK_RDAP : `SDCB_BK_RD) :
                  (ap ? `SDCB_BK_WRAP : `SDCB_BK_WR);
                next_bk0 = other_after_rw(bk0);
              end
              else
              begin
                next_bk0 = (cmd == `SDCB_CMD_READ) ?
                  (ap ? `SDCB_BK_RDAP : `SDCB_BK_RD) :
                  (ap ? `SDCB_BK_WRAP : `SDCB_BK_WR);
                next_bk1 = other_after_rw(bk1);
              end
            end
            `SDCB_CMD_ACT:
            begin
              if (sel ? (bk1 != `SDCB_BK_IDLE) : (bk0 != `SDCB_BK_IDLE))
                next_illegal = 1'b1;
              else if (sel)
                next_bk1 = `SDCB_BK_ACT;
              else
                next_bk0 = `SDCB_BK_ACT;
            end
            `SDCB_CMD_PRE:
            begin
              if (ap)
              begin
                next_bk0 = `SDCB_BK_IDLE;
                next_bk1 = `SDCB_BK_IDLE;
              end
              else if (sel)
                next_bk1 = `SDCB_BK_IDLE;
              else
                next_bk0 = `SDCB_BK_IDLE;
            end
            `SDCB_CMD_REF:
            begin
              // Refresh needs both banks idle
              if (!both_idle)
                next_illegal = 1'b1;
            end
            `SDCB_CMD_MRS:
            begin
              if (!both_idle)
                next_illegal = 1'b1;
            end
            default:
            begin
              next_bk0 = bk0;
            end
          endcase
        end
      end
    endcase
  end

  // ----------------------------------------
  // State registers
  // ----------------------------------------
  always @(posedge CLK_SYS_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      // Idle-high level, so no false enable edge after reset
      cke_prev <= 1'b1;
      mode <= `SDCB_MD_NORMAL;
      bk0 <= `SDCB_BK_IDLE;
      bk1 <= `SDCB_BK_IDLE;
      trc_cnt <= 8'h00;
    end
    else
    begin
      cke_prev <= cke;
      mode <= next_mode;
      bk0 <= next_bk0;
      bk1 <= next_bk1;
      // Load refresh timer on entry to recovery
      if ((mode != `SDCB_MD_SRREC) && (next_mode == `SDCB_MD_SRREC))
        trc_cnt <= TRC_CYC - 8'h01;
      else if (trc_cnt != 8'h00)
        trc_cnt <= trc_cnt - 8'h01;
    end
  end

  // ----------------------------------------
  // Registered outputs
  // ----------------------------------------
  always @(posedge CLK_SYS_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      MODE_O <= `SDCB_MD_NORMAL;
      BANK0_STATE_O <= `SDCB_BK_IDLE;
      BANK1_STATE_O <= `SDCB_BK_IDLE;
      ROW_ADDRESS_O <= {ROW_W{1'b0}};
      COLUMN_ADDRESS_O <= {COL_W{1'b0}};
      BANK_SEL_O <= 1'b0;
      MODE_REG_O <= {ADDR_W{1'b0}};
      ILLEGAL_O <= 1'b0;
    end
    else
    begin
      MODE_O <= next_mode;
      BANK0_STATE_O <= next_bk0;
      BANK1_STATE_O <= next_bk1;
      ILLEGAL_O <= next_illegal;
      if (cke_prev && !next_illegal && (mode == `SDCB_MD_NORMAL) &&
          (next_mode != `SDCB_MD_SELFREF))
      begin
        if (cmd == `SDCB_CMD_ACT)
        begin
          ROW_ADDRESS_O <= addr[ROW_W-1:0];
          BANK_SEL_O <= sel;
        end
        if ((cmd == `SDCB_CMD_READ) || (cmd == `SDCB_CMD_WRITE))
        begin
          // Upper two column lines are don't care
          COLUMN_ADDRESS_O <= addr[COL_W-1:0];
          BANK_SEL_O <= sel;
        end
        if ((cmd == `SDCB_CMD_MRS) && both_idle)
          MODE_REG_O <= addr;
      end
    end
  end
endmodule

// file: sdcb_cmd_state_props.sv
// Concurrent checks on the command decoder's pins and state outputs
`include "sdcb_defs.vh"
module sdcb_cmd_state_props
#(
  parameter ADDR_W = 12,
  parameter ROW_W = 11,
  parameter COL_W = 8
)
(
  // Clock and reset
  input wire CLK_SYS_I,
  input wire RST_N_I,
  // Command pins
  input wire CKE_I,
  input wire CS_N_I,
  input wire RAS_N_I,
  input wire CAS_N_I,
  input wire WE_N_I,
  input wire [ADDR_W-1:0] ADDR_I,
  // Decoder state
  input wire [2:0] MODE_O,
  input wire [2:0] BANK0_STATE_O,
  input wire [2:0] BANK1_STATE_O,
  input wire [ROW_W-1:0] ROW_ADDRESS_O,
  input wire [COL_W-1:0] COLUMN_ADDRESS_O,
  input wire [ADDR_W-1:0] MODE_REG_O,
  input wire BANK_SEL_O,
  input wire ILLEGAL_O
);
  timeunit 1ns;
  timeprecision 1ps;
  wire [3:0] cmd = {CS_N_I, RAS_N_I, CAS_N_I, WE_N_I}; // Pin command
  wire [2:0] m = MODE_O; // Short alias
  wire idle = (BANK0_STATE_O == `SDCB_BK_IDLE) && (BANK1_STATE_O == `SDCB_BK_IDLE);
  logic kp; // Clock enable one edge ago
  logic [3:0] age; // Saturates at 8: pipeline full past reset
  logic [4:0] rc; // Cycles spent in recovery
  wire ok = age[3]; // Past values all come from after reset
  wire up = CKE_I & ~kp; // Rising clock enable
  wire dn = ~CKE_I & kp; // Falling clock enable
  // Helper registers
  always @(posedge CLK_SYS_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      kp <= 1'b0;
      age <= 4'h0;
      rc <= 5'h00;
    end
    else
    begin
      kp <= CKE_I;
      age <= ok ? age : age + 4'h1;
      rc <= (m == `SDCB_MD_SRREC) ? rc + 5'h01 : 5'h00;
    end
  end
  default clocking cb @(posedge CLK_SYS_I);
  endclocking
  default disable iff (!RST_N_I);
  a_sref_entry:
    assert property (ok && dn && cmd == `SDCB_CMD_REF ##2 (m == `SDCB_MD_NORMAL && idle)
      |=> m == `SDCB_MD_SELFREF) else $error("no self-refresh entry");
  a_sref_exit:
    assert property (ok && up && cmd == `SDCB_CMD_NOP ##2 (m == `SDCB_MD_SELFREF)
      |=> m == `SDCB_MD_SRREC) else $error("no recovery after self-refresh");
  a_sref_bad_exit:
    assert property (ok && up && cmd == `SDCB_CMD_ACT ##2 (m == `SDCB_MD_SELFREF)
      |=> ILLEGAL_O) else $error("bad exit command not flagged");
  a_rec_time:
    assert property ($past(m) == `SDCB_MD_SRREC && m == `SDCB_MD_NORMAL
      |-> rc == `SDCB_TRC_CYC) else $error("recovery length wrong");
  a_pd_exit:
    assert property (ok && up ##2 (m == `SDCB_MD_PDOWN)
      |=> m == `SDCB_MD_NORMAL && idle) else $error("power-down exit wrong");
  a_susp_entry:
    assert property (ok && dn ##2 (m == `SDCB_MD_NORMAL && !idle)
      |=> m == `SDCB_MD_SUSPEND) else $error("no clock suspend");
  a_susp_exit:
    assert property (ok && up ##2 (m == `SDCB_MD_SUSPEND)
      |=> m == `SDCB_MD_NORMAL) else $error("suspend not ended");
  a_act_row:
    assert property (ok && kp && CKE_I && cmd == `SDCB_CMD_ACT && !ADDR_I[11]
      ##2 (m == `SDCB_MD_NORMAL && BANK0_STATE_O == `SDCB_BK_IDLE)
      |=> BANK0_STATE_O == `SDCB_BK_ACT && !BANK_SEL_O
      && ROW_ADDRESS_O == $past(ADDR_I[ROW_W-1:0], 3)) else $error("activate wrong");
  a_col_addr:
    assert property (ok && kp && CKE_I && !ADDR_I[11]
      && (cmd == `SDCB_CMD_READ || cmd == `SDCB_CMD_WRITE)
      ##2 (m == `SDCB_MD_NORMAL && BANK0_STATE_O != `SDCB_BK_IDLE)
      |=> !BANK_SEL_O && COLUMN_ADDRESS_O == $past(ADDR_I[COL_W-1:0], 3))
      else $error("column address wrong");
  a_mode_reg:
    assert property (ok && kp && CKE_I && cmd == `SDCB_CMD_MRS
      ##2 (m == `SDCB_MD_NORMAL && idle)
      |=> MODE_REG_O == $past(ADDR_I, 3)) else $error("mode register not loaded");
endmodule
bind sdcb_cmd_state sdcb_cmd_state_props
  #(.ADDR_W(ADDR_W), .ROW_W(ROW_W), .COL_W(COL_W)) i_props (
  .CLK_SYS_I(CLK_SYS_I), .RST_N_I(RST_N_I), .CKE_I(CKE_I), .CS_N_I(CS_N_I),
  .RAS_N_I(RAS_N_I), .CAS_N_I(CAS_N_I), .WE_N_I(WE_N_I), .ADDR_I(ADDR_I), .MODE_O(MODE_O),
  .BANK0_STATE_O(BANK0_STATE_O), .BANK1_STATE_O(BANK1_STATE_O),
  .ROW_ADDRESS_O(ROW_ADDRESS_O), .COLUMN_ADDRESS_O(COLUMN_ADDRESS_O),
  .MODE_REG_O(MODE_REG_O), .BANK_SEL_O(BANK_SEL_O), .ILLEGAL_O(ILLEGAL_O));

// file: sdcb_cmd_state_tb.sv
// Self-checking bench for the command and clock-enable decoder
`include "sdcb_defs.vh"
module sdcb_cmd_state_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam [2:0] MN = `SDCB_MD_NORMAL, MS = `SDCB_MD_SELFREF, MR = `SDCB_MD_SRREC;
  localparam [2:0] MP = `SDCB_MD_PDOWN, MU = `SDCB_MD_SUSPEND, MX = 3'h7;
  localparam [2:0] BI = `SDCB_BK_IDLE, BA = `SDCB_BK_ACT, BR = `SDCB_BK_RD;
  localparam [2:0] BW = `SDCB_BK_WR, BWA = `SDCB_BK_WRAP;
  localparam [3:0] CN = `SDCB_CMD_NOP, CB = `SDCB_CMD_BST, CR = `SDCB_CMD_READ;
  localparam [3:0] CW = `SDCB_CMD_WRITE, CA = `SDCB_CMD_ACT, CP = `SDCB_CMD_PRE;
  localparam [3:0] CF = `SDCB_CMD_REF, CM = `SDCB_CMD_MRS, DS = 4'hf;
  logic clk = 1'b0; // System clock
  logic rst_n = 1'b0; // Reset, active low
  logic r_cke = 1'b1; // Requests to the model
  logic [3:0] r_cmd = 4'h7;
  logic [11:0] r_addr = 12'h000;
  logic cke; // Pins
  logic [3:0] cmd;
  logic [11:0] addr;
  logic [2:0] mode, b0, b1; // Decoder state
  logic ill;
  logic [31:0] seed = 32'h0000_efe2; // Random source
  int cyc = 0, errors = 0, total_checks = 0;
  int qd[$]; // Due cycle of each expectation
  logic [9:0] qe[$]; // Expected {illegal, bank1, bank0, mode}
  sdcb_ctrl_model i_sdcb_ctrl_model (.clk_i(clk), .cke_i(r_cke), .cmd_i(r_cmd),
    .addr_i(r_addr), .cke_o(cke), .cmd_o(cmd), .addr_o(addr));
  sdcb_cmd_state i_sdcb_cmd_state (.CLK_SYS_I(clk), .RST_N_I(rst_n), .CKE_I(cke),
    .CS_N_I(cmd[3]), .RAS_N_I(cmd[2]), .CAS_N_I(cmd[1]), .WE_N_I(cmd[0]), .ADDR_I(addr),
    .MODE_O(mode), .BANK0_STATE_O(b0), .BANK1_STATE_O(b1), .ROW_ADDRESS_O(),
    .COLUMN_ADDRESS_O(), .BANK_SEL_O(), .MODE_REG_O(), .ILLEGAL_O(ill));
  // Clock at 4 ns
  initial
    forever #2 clk = ~clk;
  // Cycle count for due times and timeout
  always @(posedge clk)
    cyc <= cyc + 1;
  // Ends the run with the verdict
  task automatic wrap_up;
    if (errors == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Next random word
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // One command; a mode of MX means no check, results land 4 cycles on
  task automatic step(input logic k, input logic [3:0] c, input logic bk, input logic ap,
    input logic [2:0] em, e0, e1, input logic ei);
    @(posedge clk);
    seed = lfsr(seed);
    r_cke = k;
    r_cmd = c;
    r_addr = {bk, ap, seed[9:0]};
    if (em != MX)
    begin
      qd.push_back(cyc + 4);
      qe.push_back({ei, e1, e0, em});
    end
  endtask
  // Watches the outputs and retires the oldest expectation
  always @(negedge clk)
  begin
    if (cyc > 400)
    begin
      errors++;
      $display("FAIL %0t timeout", $time);
      wrap_up();
    end
    else if (qd.size() != 0 && qd[0] == cyc)
    begin
      total_checks++;
      if ({ill, b1, b0, mode} !== qe[0])
      begin
        errors++;
        $display("FAIL %0t state %h expected %h", $time, {ill, b1, b0, mode}, qe[0]);
      end
      void'(qd.pop_front());
      void'(qe.pop_front());
    end
  end
  // Main sequence
  initial
  begin
    repeat (10) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    repeat (8) step(1, CN, 0, 0, MX, BI, BI, 0);
    step(1, CM, 0, 0, MN, BI, BI, 0);
    step(1, CF, 0, 0, MN, BI, BI, 0);
    step(1, CA, 0, 0, MN, BA, BI, 0);
    step(1, CA, 1, 1, MN, BA, BA, 0);
    step(1, CA, 0, 0, MN, BA, BA, 1);
    step(1, CM, 0, 0, MN, BA, BA, 1);
    step(1, CR, 0, 0, MN, BR, BA, 0);
    step(1, CW, 1, 0, MN, BA, BW, 0);
    step(1, DS, 0, 0, MN, BA, BW, 0);
    step(1, CB, 0, 0, MN, BA, BA, 0);
    step(1, CW, 0, 1, MN, BWA, BA, 0);
    step(1, CP, 1, 0, MN, BWA, BI, 0);
    step(1, CR, 1, 0, MN, BWA, BI, 1);
    step(0, CN, 0, 0, MU, BWA, BI, 0);
    step(0, CA, 1, 0, MU, BWA, BI, 0);
    step(1, CN, 0, 0, MN, BWA, BI, 0);
    step(1, CP, 0, 1, MN, BI, BI, 0);
    step(0, CN, 0, 0, MP, BI, BI, 0);
    step(0, CA, 0, 0, MP, BI, BI, 0);
    step(1, CA, 0, 0, MN, BI, BI, 0);
    step(1, CN, 0, 0, MN, BI, BI, 0);
    step(0, CF, 0, 0, MS, BI, BI, 0);
    step(0, CA, 0, 0, MS, BI, BI, 0);
    step(1, CN, 0, 0, MR, BI, BI, 0);
    repeat (14) step(1, CN, 0, 0, MR, BI, BI, 0);
    step(1, CN, 0, 0, MN, BI, BI, 0);
    step(0, CF, 0, 0, MS, BI, BI, 0);
    step(1, DS, 0, 0, MR, BI, BI, 0);
    step(0, CN, 0, 0, MP, BI, BI, 0);
    step(1, CN, 0, 0, MN, BI, BI, 0);
    step(0, CF, 0, 0, MS, BI, BI, 0);
    step(1, CA, 0, 0, MR, BI, BI, 1);
    step(1, CN, 0, 0, MR, BI, BI, 0);
    repeat (5) step(1, CN, 0, 0, MX, BI, BI, 0);
    if (qd.size() != 0)
    begin
      errors++;
      $display("FAIL %0t expectations left unchecked", $time);
    end
    wrap_up();
  end
endmodule

// file: sdcb_ctrl_model.sv
// Memory-controller model driving the decoder's command pins
module sdcb_ctrl_model
(
  // Clock
  input wire clk_i,
  // Requests from the bench
  input wire cke_i,
  input wire [3:0] cmd_i,
  input wire [11:0] addr_i,
  // Device pins
  output logic cke_o,
  output logic [3:0] cmd_o,
  output logic [11:0] addr_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Pins move only on the falling edge, clear of sampling
  always @(negedge clk_i)
  begin
    cke_o <= cke_i;
    cmd_o <= cmd_i;
    // Deselected: address is garbage, never the held value
    if (cmd_i[3])
      addr_o <= ~addr_o;
    else
      addr_o <= addr_i;
  end
endmodule

// file: sdcb_defs.vh
// Constants for the two-bank command and clock-enable state logic
`ifndef SDCB_DEFS_VH
`define SDCB_DEFS_VH
// ----------------------------------------
// Command encodings {cs_n, ras_n, cas_n, we_n}
// ----------------------------------------
`define SDCB_CMD_NOP 4'h7
`define SDCB_CMD_BST 4'h6
`define SDCB_CMD_READ 4'h5
`define SDCB_CMD_WRITE 4'h4
`define SDCB_CMD_ACT 4'h3
`define SDCB_CMD_PRE 4'h2
`define SDCB_CMD_REF 4'h1
`define SDCB_CMD_MRS 4'h0
// ----------------------------------------
// Bank states
// ----------------------------------------
`define SDCB_BK_IDLE 3'h0
`define SDCB_BK_ACT 3'h1
`define SDCB_BK_RD 3'h2
`define SDCB_BK_WR 3'h3
`define SDCB_BK_RDAP 3'h4
`define SDCB_BK_WRAP 3'h5
// ----------------------------------------
// Global clock-enable modes
// ----------------------------------------
`define SDCB_MD_NORMAL 3'h0
`define SDCB_MD_SELFREF 3'h1
`define SDCB_MD_SRREC 3'h2
`define SDCB_MD_PDOWN 3'h3
`define SDCB_MD_SUSPEND 3'h4
// ----------------------------------------
// Address field positions
// ----------------------------------------
`define SDCB_BANK_BIT 11
`define SDCB_AP_BIT 10
// ----------------------------------------
// Timing: refresh cycle time in ps, clock period in ps
// ----------------------------------------
`define SDCB_TRC_PS 60000
`define SDCB_TCK_PS 4000
`define SDCB_TRC_CYC ((`SDCB_TRC_PS + `SDCB_TCK_PS - 1) / `SDCB_TCK_PS)
`endif

// file: sdcb_sync2.v
// Two-flop synchroniser for pin inputs
module sdcb_sync2
#(
  parameter W = 1
)
(
  // Clock and reset
  input wire clk_i,
  input wire rst_n_i,
  // Data
  input wire [W-1:0] d_i,
  output reg [W-1:0] q_o
);
  // First stage, read only by the second
  reg [W-1:0] meta;

  // ----------------------------------------
  // Sync stages
  // ----------------------------------------
  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      meta <= {W{1'b0}};
      q_o <= {W{1'b0}};
    end
    else
    begin
      meta <= d_i;
      q_o <= meta;
    end
  end
endmodule
